// *** design/pmm_params.svh ***
// Constants for the power manager monitor poller.
// Assumes a 10 MHz ref_clk; included by bare name.
`ifndef PMM_PARAMS_SVH
`define PMM_PARAMS_SVH
`define PMM_CLK_HZ 10000000
`define PMM_REFRESH_MS 1000
`define PMM_REFRESH_CYC ((`PMM_CLK_HZ / 1000) * `PMM_REFRESH_MS)
`define PMM_HOLD_MS 150
`define PMM_VOLT_W 12
`define PMM_CURR_W 8
`define PMM_TEMP_W 8
`define PMM_FRAME_W 28
`define PMM_STAT_W 8
`define PMM_NCONV 4
`define PMM_NGROUP 2
`define PMM_BIT_DIV 40
`endif

// *** design/pmm_pkg.sv ***
// Types shared by the poller and its converter link shifter.
// Assumes pmm_params.svh is on the include path.
`include "pmm_params.svh"
package pmm_pkg;
    // One converter reading as stored in the monitor registers
    typedef struct packed {
        logic [`PMM_VOLT_W-1:0] volt;
        logic [`PMM_CURR_W-1:0] curr;
        logic [`PMM_TEMP_W-1:0] temp;
    } pmm_reading_s;
    // Per-group options
    typedef struct packed {
        logic auto_on;
        logic p_mon;
        logic s_mon;
    } pmm_group_opt_s;
    typedef enum logic [1:0] {PMM_Q_PARAM, PMM_Q_STATUS} pmm_query_e;
endpackage

// *** design/pmm_link.sv ***
// Serial shifter for the converter-side bus: sends a query byte, receives a reply frame.
// Assumes link_clk and link_din are asynchronous pins, sampled here on ref_clk.
`timescale 1ns/1ns
module pmm_link
    import pmm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request side
    input wire logic start,
    input wire logic [7:0] query,
    output logic busy,
    output logic done,
    output logic [`PMM_FRAME_W-1:0] frame,
    // Pins
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    output logic link_oe
);
    typedef enum {LK_IDLE, LK_SEND, LK_RECV} pmm_lk_e;
    pmm_lk_e st_reg; // Shifter state
    logic [1:0] clk_sync_reg; // Link clock synchroniser
    logic [1:0] din_sync_reg; // Data synchroniser
    logic clk_prev_reg; // Last synced clock, for edge find
    logic [5:0] cnt_reg; // Bit counter
    logic [7:0] sh_reg; // Outgoing shift
    logic [`PMM_FRAME_W-1:0] rx_reg; // Incoming shift
    wire rise = clk_sync_reg[1] & ~clk_prev_reg;
    wire fall = ~clk_sync_reg[1] & clk_prev_reg;
    ////////////////////////////////////////////////////////////////
    // Synchronisers: first stage read only by second stage
    always_ff @(posedge ref_clk) begin
        clk_sync_reg <= {clk_sync_reg[0], link_clk};
        din_sync_reg <= {din_sync_reg[0], link_din};
        clk_prev_reg <= clk_sync_reg[1];
    end
    ////////////////////////////////////////////////////////////////
    // Send on falling edges, sample on rising edges
    always_ff @(posedge ref_clk) begin
        done <= 1'b0;
        if (rst) begin
            st_reg <= LK_IDLE;
            cnt_reg <= 6'h00;
            sh_reg <= 8'h00;
            rx_reg <= '0;
            frame <= '0;
            link_dout <= 1'b0;
            link_oe <= 1'b0;
        end else begin
            case (st_reg)
                LK_IDLE: begin
                    // The raised enable is the request: the converters clock only after it
                    link_oe <= start;
                    if (start) begin
                        // First bit stands before the first rising edge
                        link_dout <= query[7];
                        sh_reg <= {query[6:0], 1'b0};
                        cnt_reg <= 6'($bits(query) - 1);
                        st_reg <= LK_SEND;
                    end
                end
                LK_SEND: begin
                    if (fall) begin
                        if (cnt_reg == 6'h00) begin
                            // Release the line before the reply
                            link_oe <= 1'b0;
                            cnt_reg <= 6'(`PMM_FRAME_W);
                            st_reg <= LK_RECV;
                        end else begin
                            link_dout <= sh_reg[7];
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg - 6'h01;
                        end
                    end
                end
                LK_RECV: begin
                    link_oe <= 1'b0;
                    if (rise && cnt_reg != 6'h00) begin
                        rx_reg <= {rx_reg[`PMM_FRAME_W-2:0], din_sync_reg[1]};
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                    if (fall && cnt_reg == 6'h00) begin
                        // Finish on the closing fall, so a following query never sees it as a shift edge
                        frame <= rx_reg;
                        done <= 1'b1;
                        st_reg <= LK_IDLE;
                    end
                end
                default: st_reg <= LK_IDLE;
            endcase
        end
    end
    assign busy = (st_reg != LK_IDLE);
endmodule

// *** design/pmm_poller.sv ***
// Power manager monitor poller: periodic converter polling, monitor registers, host hold.
// Assumes host I2C logic sits outside and obeys i2c_hold; converters answer on link pins.
`timescale 1ns/1ns
module pmm_poller
    import pmm_pkg::*;
#(
    parameter int NCONV = `PMM_NCONV,
    parameter int NGROUP = `PMM_NGROUP,
    parameter int REFRESH_CYC = `PMM_REFRESH_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Per-group options and membership
    input wire pmm_group_opt_s [NGROUP-1:0] group_opt,
    input wire logic [NCONV-1:0] conv_group,
    input wire logic [NCONV-1:0] conv_configured,
    input wire logic intermediate_bus_power,
    // Power-good pin, one per converter, asynchronous
    input wire logic [NCONV-1:0] pgood_n,
    // Host I2C arbitration
    input wire logic i2c_req,
    output logic i2c_hold,
    // Converter-side bus pins
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    output logic link_oe,
    // Monitor registers and status
    output pmm_reading_s [NCONV-1:0] monitor_value,
    output logic [NCONV-1:0][`PMM_STAT_W-1:0] status_value,
    output logic [NCONV-1:0] pgood_lost,
    output logic [NGROUP-1:0] group_on,
    output logic refresh_pulse
);
    typedef enum {PL_IDLE, PL_PICK, PL_PARAM, PL_STAT, PL_NEXT} pmm_pl_e;
    pmm_pl_e st_reg; // Poll state
    logic [31:0] tick_reg; // Refresh period counter
    logic [3:0] idx_reg; // Converter under poll
    logic start_reg; // Query launch
    logic [7:0] query_reg; // Query code with address
    logic [NCONV-1:0][1:0] pg_sync_reg; // Power-good synchronisers
    wire lk_busy;
    wire lk_done;
    wire [`PMM_FRAME_W-1:0] lk_frame;
    // Group option of the converter under poll
    wire pmm_group_opt_s cur_opt = group_opt[conv_group[idx_reg[$clog2(NCONV)-1:0]]];
    wire period_end = (tick_reg == 32'(REFRESH_CYC - 1));
    ////////////////////////////////////////////////////////////////
    // Converter link shifter
    pmm_link u_link (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(start_reg),
        .query(query_reg),
        .busy(lk_busy),
        .done(lk_done),
        .frame(lk_frame),
        .link_clk(link_clk),
        .link_din(link_din),
        .link_dout(link_dout),
        .link_oe(link_oe)
    );
    ////////////////////////////////////////////////////////////////
    // Refresh period: one second at 10 MHz
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_reg <= 32'h0;
            refresh_pulse <= 1'b0;
        end else begin
            tick_reg <= period_end ? 32'h0 : tick_reg + 32'h1;
            refresh_pulse <= period_end;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Poll sequencer: ascending addresses, one at a time
    always_ff @(posedge ref_clk) begin
        start_reg <= 1'b0;
        if (rst) begin
            st_reg <= PL_IDLE;
            idx_reg <= 4'h0;
            query_reg <= 8'h00;
            monitor_value <= '0;
            status_value <= '0;
        end else begin
            case (st_reg)
                PL_IDLE: begin
                    if (period_end) begin
                        idx_reg <= 4'h0;
                        st_reg <= PL_PICK;
                    end
                end
                PL_PICK: begin
                    // Options are looked up by group, never by converter
                    if (cur_opt.p_mon) begin
                        query_reg <= {PMM_Q_PARAM, 2'b00, idx_reg};
                        start_reg <= 1'b1;
                        st_reg <= PL_PARAM;
                    end else if (cur_opt.s_mon) begin
                        query_reg <= {PMM_Q_STATUS, 2'b00, idx_reg};
                        start_reg <= 1'b1;
                        st_reg <= PL_STAT;
                    end else begin
                        st_reg <= PL_NEXT;
                    end
                end
                PL_PARAM: begin
                    if (lk_done) begin
                        // Reply carries 12-bit volt, 8-bit current, 8-bit temperature
                        monitor_value[idx_reg] <= lk_frame;
                        if (cur_opt.s_mon) begin
                            query_reg <= {PMM_Q_STATUS, 2'b00, idx_reg};
                            start_reg <= 1'b1;
                            st_reg <= PL_STAT;
                        end else begin
                            st_reg <= PL_NEXT;
                        end
                    end
                end
                PL_STAT: begin
                    if (lk_done) begin
                        status_value[idx_reg] <= lk_frame[`PMM_STAT_W-1:0];
                        st_reg <= PL_NEXT;
                    end
                end
                PL_NEXT: begin
                    if (idx_reg == 4'(NCONV - 1)) begin
                        st_reg <= PL_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 4'h1;
                        st_reg <= PL_PICK;
                    end
                end
                default: st_reg <= PL_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // Host hold: converter-side traffic wins; long polls need a patient host
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            i2c_hold <= 1'b0;
        end else begin
            i2c_hold <= i2c_req & (lk_busy | start_reg);
        end
    end
    ////////////////////////////////////////////////////////////////
    // Power-good watch runs always, independent of status option
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pg_sync_reg <= '0;
            pgood_lost <= '0;
        end else begin
            for (int i = 0; i < NCONV; i++) begin
                pg_sync_reg[i] <= {pg_sync_reg[i][0], pgood_n[i]};
                pgood_lost[i] <= pg_sync_reg[i][1];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // Auto-on per group
    genvar g;
    generate
        for (g = 0; g < NGROUP; g++) begin : gen_auto
            wire all_cfg;
            logic [NCONV-1:0] member;
            always_comb begin
                for (int i = 0; i < NCONV; i++) begin
                    member[i] = (int'(conv_group[i]) == g);
                end
            end
            assign all_cfg = &(conv_configured | ~member);
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    group_on[g] <= 1'b0;
                end else if (group_opt[g].auto_on & intermediate_bus_power & all_cfg) begin
                    group_on[g] <= 1'b1;
                end else if (!intermediate_bus_power) begin
                    group_on[g] <= 1'b0;
                end
            end
        end
    endgenerate
    // Share duty, setpoint tracking, temperature correction and continuous
    // measurement live inside each converter; readings arrive already corrected.
endmodule

// *** sim/pmm_poller_sva.sv ***
// Checker for the monitor poller: refresh timing, host hold, option gating.
// Assumes it is bound onto pmm_poller and sees only its ports.
`timescale 1ns/1ns
`include "pmm_params.svh"
module pmm_poller_sva
    import pmm_pkg::*;
#(
    parameter int NCONV = `PMM_NCONV,
    parameter int NGROUP = `PMM_NGROUP,
    parameter int REFRESH_CYC = `PMM_REFRESH_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Poller inputs
    input wire pmm_group_opt_s [NGROUP-1:0] group_opt,
    input wire logic [NCONV-1:0] conv_group,
    input wire logic [NCONV-1:0] conv_configured,
    input wire logic intermediate_bus_power,
    input wire logic [NCONV-1:0] pgood_n,
    input wire logic i2c_req,
    input wire logic link_clk,
    input wire logic link_din,
    // Poller outputs
    input wire logic i2c_hold,
    input wire logic link_dout,
    input wire logic link_oe,
    input wire pmm_reading_s [NCONV-1:0] monitor_value,
    input wire logic [NCONV-1:0][`PMM_STAT_W-1:0] status_value,
    input wire logic [NCONV-1:0] pgood_lost,
    input wire logic [NGROUP-1:0] group_on,
    input wire logic refresh_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Cycles since the last refresh; the first pulse after reset only arms it
    int cnt;
    logic seen;
    always_ff @(posedge ref_clk) begin
        cnt <= (rst || refresh_pulse) ? 0 : cnt + 1;
        seen <= !rst && (seen || refresh_pulse);
    end
    ////////////////////////////////////////////////////////////////////////////
    period_fixed_a: assert property (seen && (refresh_pulse || cnt >= REFRESH_CYC - 1) // period
        |-> refresh_pulse && cnt == REFRESH_CYC - 1) else $error("refresh period wrong");
    pulse_single_a: assert property (refresh_pulse |=> !refresh_pulse) // pulse
        else $error("refresh pulse too long");
    hold_on_a: assert property (i2c_req && link_oe |-> ##[0:2] i2c_hold) // hold
        else $error("host not held");
    hold_off_a: assert property (!i2c_req [*2] |-> !i2c_hold) // release
        else $error("host held without request");
    pgood_follow_a: assert property (pgood_lost == $past(pgood_n, 3)) // power-good
        else $error("power-good loss not tracked");
    auto_on_a: assert property ((group_opt[0].auto_on && intermediate_bus_power // turn-on
        && conv_configured == '1) [*4] |-> group_on[0]) else $error("group not switched on");
    status_gate_a: assert property ($changed(status_value) // status
        |-> group_opt[0].s_mon || group_opt[1].s_mon) else $error("status read without option");
    param_gate_a: assert property ($changed(monitor_value) // readings
        |-> group_opt[0].p_mon || group_opt[1].p_mon) else $error("readings without option");
    // Main scenarios reached
    cover property (i2c_hold);
    cover property (refresh_pulse && seen);
    cover property (|pgood_lost);
endmodule

// *** sim/pmm_conv_model.sv ***
// Behavioural converters on the link: clock runs only within a frame.
// Assumes one query byte MSB first, then a 28-bit reply MSB first.
`timescale 1ns/1ns
module pmm_conv_model (
    // From the poller
    input wire logic link_dout,
    input wire logic link_oe,
    // Reply variation chosen by the bench
    input wire logic [7:0] salt,
    // To the poller
    output logic link_clk,
    output logic link_din
);
    logic [7:0] q;
    logic [27:0] f;
    logic [7:0] log_q [$];
    // Level wait on the raised enable; the clock stands still until it is seen
    initial begin
        link_clk = 1'b0;
        link_din = 1'b1;
        forever begin
            wait (link_oe === 1'b1);
            #37;
            for (int i = 7; i >= 0; i--) begin
                #400 link_clk = 1'b1;
                q[i] = link_dout;
                #400 link_clk = 1'b0;
            end
            log_q.push_back(q);
            // Voltage 12 bits, current and temperature 8 each
            f = q[6] ? {20'h00000, q[3:0], salt[3:0]} : {salt, q[3:0], ~salt, 8'(salt + q[3:0])};
            for (int i = 27; i >= 0; i--) begin
                link_din = f[i];
                #400 link_clk = 1'b1;
                #400 link_clk = 1'b0;
            end
            // Released line shows the inverse of its last bit
            link_din = ~f[0];
        end
    end
endmodule

// *** sim/pmm_poller_test.sv ***
// Self-checking bench for the monitor poller with the converter model.
// Assumes the design files compile first; the checker is bound at the foot.
`timescale 1ns/1ns
module pmm_poller_test;
    import pmm_pkg::*;
    localparam int RC = 4000;
    // Row: group 0 options, group 1 options, queries expected
    typedef struct packed {logic [2:0] g0; logic [2:0] g1; logic [3:0] n;} pmm_row_s;
    pmm_row_s rows [4] = '{'{3'h2, 3'h0, 4'h2}, '{3'h0, 3'h1, 4'h2}, '{3'h3, 3'h2, 4'h6}, '{3'h0, 3'h0, 4'h0}};
    logic ref_clk = 1'b0, rst = 1'b1, intermediate_bus_power = 1'b0, i2c_req = 1'b0;
    pmm_group_opt_s [1:0] group_opt = '0;
    logic [3:0] conv_group = 4'hC, conv_configured = 4'h0, pgood_n = 4'h0, pgood_lost;
    logic [7:0] salt = 8'h00;
    logic i2c_hold, link_clk, link_din, link_dout, link_oe, refresh_pulse;
    pmm_reading_s [3:0] monitor_value;
    logic [3:0][7:0] status_value;
    logic [1:0] group_on;
    pmm_group_opt_s o;
    int err_total = 0, n_compared = 0, k;
    always #50 ref_clk = ~ref_clk;
    pmm_poller #(.NCONV(4), .NGROUP(2), .REFRESH_CYC(RC)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .group_opt(group_opt), .conv_group(conv_group), .conv_configured(conv_configured),
        .intermediate_bus_power(intermediate_bus_power), .pgood_n(pgood_n), .i2c_req(i2c_req),
        .i2c_hold(i2c_hold), .link_clk(link_clk), .link_din(link_din), .link_dout(link_dout),
        .link_oe(link_oe), .monitor_value(monitor_value), .status_value(status_value),
        .pgood_lost(pgood_lost), .group_on(group_on), .refresh_pulse(refresh_pulse));
    pmm_conv_model i_conv (.link_dout(link_dout), .link_oe(link_oe), .salt(salt), .link_clk(link_clk),
        .link_din(link_din));
    task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait for a refresh pulse or for link activity
    task automatic wait_for(input bit on_link);
        int t;
        t = 0;
        @(negedge ref_clk);
        while ((on_link ? link_oe : refresh_pulse) !== 1'b1 && t < RC + 10) begin
            @(negedge ref_clk);
            t++;
        end
        if (t >= RC + 10) err_total++;
        @(negedge ref_clk);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #6000000;
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("idle", {group_on, pgood_lost, refresh_pulse, i2c_hold, monitor_value[0][7:0]}, 28'h0);
        // Option rows: one full poll each, with fresh reply values
        for (int r = 0; r < 4; r++) begin
            group_opt[0] = rows[r].g0;
            group_opt[1] = rows[r].g1;
            salt = 8'(8'h11 * (r + 1));
            wait_for(1'b0);
            i_conv.log_q.delete();
            wait_for(1'b0);
            chk("queries", 28'(i_conv.log_q.size()), 28'(rows[r].n)); // count
            k = 0;
            for (int a = 0; a < 4; a++) begin
                o = group_opt[conv_group[a]];
                if (o.p_mon) begin
                    chk("param query", i_conv.log_q[k], {4'h0, 4'(a)}); // order
                    chk("reading", monitor_value[a], {salt, 4'(a), ~salt, 8'(salt + a)}); // value
                    k++;
                end
                if (o.s_mon) begin
                    chk("status query", i_conv.log_q[k], {4'h4, 4'(a)}); // order
                    chk("status", status_value[a], {4'(a), salt[3:0]}); // value
                    k++;
                end
            end
            repeat (RC - 500) @(negedge ref_clk);
        end
        // Host held during link activity, freed after the poll
        group_opt[0] = 3'h2;
        i2c_req = 1'b1;
        wait_for(1'b1);
        repeat (2) @(negedge ref_clk);
        chk("hold", i2c_hold, 1'b1); // held
        repeat (2500) @(negedge ref_clk); // host timeout past poll time
        chk("hold", i2c_hold, 1'b0); // freed
        i2c_req = 1'b0;
        // Power-good loss seen without status option
        pgood_n = 4'h2;
        repeat (6) @(negedge ref_clk);
        chk("pgood", pgood_lost, 4'h2); // loss
        pgood_n = 4'h0;
        // Auto-on needs power and every converter of the group configured
        group_opt[0] = 3'h6;
        conv_configured = 4'hE;
        intermediate_bus_power = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("group on", group_on, 2'h0); // unconfigured
        conv_configured = 4'hF;
        repeat (10) @(negedge ref_clk);
        chk("group on", group_on, 2'h1); // per group
        intermediate_bus_power = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("group on", group_on, 2'h0); // power lost
        // Second reset clears stored readings
        rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("reset", monitor_value[0], 28'h0);
        end_of_test();
    end
endmodule
bind pmm_poller pmm_poller_sva #(.NCONV(NCONV), .NGROUP(NGROUP), .REFRESH_CYC(REFRESH_CYC)) i_sva (
    .ref_clk(ref_clk), .rst(rst), .group_opt(group_opt), .conv_group(conv_group),
    .conv_configured(conv_configured), .intermediate_bus_power(intermediate_bus_power), .pgood_n(pgood_n),
    .i2c_req(i2c_req), .link_clk(link_clk), .link_din(link_din), .i2c_hold(i2c_hold), .link_dout(link_dout),
    .link_oe(link_oe), .monitor_value(monitor_value), .status_value(status_value), .pgood_lost(pgood_lost),
    .group_on(group_on), .refresh_pulse(refresh_pulse));
